// [core/pix_adjust_pkg.sv]
package pix_adjust_pkg;

	// Pixel and coefficient widths
	localparam int PIX_W = 10;
	localparam int GAIN_FRAC = 8;
	localparam int GAIN_W = 12;
	localparam int COEF_W = 9;
	localparam int COEF_FRAC = 7;
	localparam int OFS_W = 11;

	// Register offsets
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_LUMA_GAIN = 4'h1;
	localparam logic [3:0] A_OFFSET = 4'h2;
	localparam logic [3:0] A_TONE = 4'h3;
	localparam logic [3:0] A_WB_SEL = 4'h4;
	localparam logic [3:0] A_WB_GAIN = 4'h5;
	localparam logic [3:0] A_AUTO_WB = 4'h6;
	localparam logic [3:0] A_MIX_ROW = 4'h7;
	localparam logic [3:0] A_MIX_COL = 4'h8;
	localparam logic [3:0] A_MIX_COEF = 4'h9;
	localparam logic [3:0] A_LAYOUT = 4'ha;
	localparam logic [3:0] A_STATUS = 4'hb;

	// Control bit positions
	localparam int CTRL_FIXED_GAIN = 0;
	localparam int CTRL_DEFAULTS = 1;

	// Reset values and limits, fixed point
	localparam logic [GAIN_W-1:0] UNITY_GAIN = 12'h100;
	localparam logic [GAIN_W-1:0] WB_MAX_GAIN = 12'h800;
	localparam logic [GAIN_W-1:0] LUMA_MAX_GAIN = 12'h7f8;
	localparam logic [OFS_W-1:0] OFS_MIN = 11'h7cd;
	localparam logic [OFS_W-1:0] OFS_MAX = 11'h100;
	localparam logic [7:0] TONE_ONE = 8'h64;
	localparam logic [7:0] TONE_MIN = 8'h2d;
	localparam logic [COEF_W-1:0] COEF_ONE = 9'h080;
	localparam logic [COEF_W-1:0] COEF_MIN = 9'h180;
	localparam logic [COEF_W-1:0] COEF_MAX = 9'h07e;
	localparam logic [PIX_W-1:0] PIX_MAX = 10'h3ff;

	// Selector codes
	typedef enum logic [1:0] {
		WB_NONE = 2'b00,
		WB_RED = 2'b01,
		WB_BLUE = 2'b10
	} wb_sel_t;

	typedef enum logic [1:0] {
		CH_R = 2'b00,
		CH_G = 2'b01,
		CH_B = 2'b10
	} chan_t;

	// Output layouts
	localparam logic [3:0] LAY_MONO8 = 4'h0;
	localparam logic [3:0] LAY_RGB8 = 4'h1;
	localparam logic [3:0] LAY_BGR8 = 4'h2;
	localparam logic [3:0] LAY_YUV411_8 = 4'h3;
	localparam logic [3:0] LAY_YUV422_8 = 4'h4;
	localparam logic [3:0] LAY_BAYER8 = 4'h5;
	localparam logic [3:0] LAY_BAYER10 = 4'h6;

	// Auto white balance statistics window, log2 of the pixel count
	localparam int AWB_SAMPLES_LOG2 = 10;

endpackage

// [core/tone_curve.sv]
`timescale 1ns/1ps
module tone_curve
	import pix_adjust_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pixel in
	input wire logic [PIX_W-1:0] pix_in,
	// Exponent, hundredths
	input wire logic [7:0] exponent,
	// Pixel out, one cycle later
	output logic [PIX_W-1:0] pix_out
);

	logic [PIX_W-1:0] lift; // Square-root-like boost of the pixel
	logic [15:0] wgt; // Blend weight toward the boost, 0..55
	logic [PIX_W+7:0] mix; // Blended result

	// Approximate x^g as a blend between x and a 0.45 curve
	// Trade-off: piecewise blend instead of a full power table keeps area low
	always_comb begin
		lift = pix_in + ((PIX_MAX - pix_in) >> 1);
		wgt = 16'(TONE_ONE - exponent);
		mix = 18'(pix_in) * 18'(TONE_ONE - TONE_MIN - wgt[7:0])
			+ 18'(lift) * 18'(wgt[7:0]);
	end

	// Registered output, exponent one gives identity
	always_ff @(posedge clk) begin
		if (reset) begin
			pix_out <= '0;
		end else if (exponent >= TONE_ONE) begin
			pix_out <= pix_in;
		end else begin
			pix_out <= PIX_W'(mix / 18'(TONE_ONE - TONE_MIN));
		end
	end

endmodule

// [core/pixel_color_adjust_pipeline.sv]
`timescale 1ns/1ps
// Contract
// R1 - Luma gain is 10^(dB/20), 0..18 dB
// R2 - Luma gain applies only in fixed gain mode
// R3 - Offset adds -5..+25 percent of full scale
// R4 - Offset resets to zero percent
// R5 - Negative offset may prevent full-scale output
// R6 - Tone exponent 0.45..1.00, reset 1.00
// R7 - Colour stages only in colour variant
// R8 - WB gain routed by channel select
// R9 - WB gain limited one to eight
// R10 - Single shot request runs one auto WB
// R11 - Successful auto WB writes red and blue
// R12 - WB only for listed 8/10 bit layouts
// R13 - Matrix uses one minus off-diagonals
// R14 - Row and column select reset to R
// R15 - Pairs select the six off-diagonals
// R16 - Diagonal fixed at one, read one
// R17 - Coefficients -1..+0.99, reset zero
// R18 - Matrix only RGB/BGR/YUV, bypass Bayer
// R19 - Stage order fixed, each stage saturates
// R20 - Active settings load at frame start
module pixel_color_adjust_pipeline
	import pix_adjust_pkg::*;
#(
	parameter bit COLOR = 1'b1,
	parameter logic [GAIN_W-1:0] WB_RESET = UNITY_GAIN
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Pixel input
	input wire logic in_valid,
	input wire logic in_sof,
	input wire logic [PIX_W-1:0] in_r,
	input wire logic [PIX_W-1:0] in_g,
	input wire logic [PIX_W-1:0] in_b,
	// Pixel output
	output logic out_valid,
	output logic out_sof,
	output logic [PIX_W-1:0] out_r,
	output logic [PIX_W-1:0] out_g,
	output logic [PIX_W-1:0] out_b
);

	// Shadow settings written by software
	logic fixed_gain_mode_reg;
	logic [GAIN_W-1:0] luma_gain_reg; // Linear gain, 8 fraction bits
	logic [OFS_W-1:0] pixel_offset_level_reg; // Signed, in pixel codes
	logic [7:0] tone_curve_exponent_reg; // Hundredths
	wb_sel_t wb_channel_select_reg;
	logic [GAIN_W-1:0] wb_gain_reg [2]; // Red, blue
	logic auto_wb_request_reg;
	chan_t mix_row_select_reg;
	chan_t mix_col_select_reg;
	logic [COEF_W-1:0] color_mix_coeff_reg [3][3];
	logic [3:0] output_pixel_layout_reg;

	// Active copies, loaded at start of frame
	logic [GAIN_W-1:0] act_luma;
	logic [OFS_W-1:0] act_ofs;
	logic [7:0] act_tone;
	logic [GAIN_W-1:0] act_wb [2];
	logic [COEF_W-1:0] act_mix [3][3];
	logic act_wb_en;
	logic act_mix_en;
	logic s1_valid, s1_sof, s2_valid, s2_sof, s3_valid, s3_sof; // Stages

	// Auto white balance state
	typedef enum logic [1:0] {
		AWB_IDLE = 2'b00,
		AWB_WAIT = 2'b01,
		AWB_SUM = 2'b10,
		AWB_DONE = 2'b11
	} awb_state_t;
	awb_state_t awb_state_reg;
	logic [PIX_W+AWB_SAMPLES_LOG2-1:0] sum_reg [3];
	logic [AWB_SAMPLES_LOG2:0] awb_cnt_reg;
	logic awb_ok_reg; // Last run succeeded

	// Layout decode
	logic wb_layout_ok;
	logic mix_layout_ok;
	always_comb begin
		wb_layout_ok = output_pixel_layout_reg inside {LAY_RGB8, LAY_BGR8,
			LAY_YUV411_8, LAY_YUV422_8, LAY_BAYER8, LAY_BAYER10}; // R12
		mix_layout_ok = output_pixel_layout_reg inside {LAY_RGB8, LAY_BGR8,
			LAY_YUV411_8, LAY_YUV422_8}; // R18
	end

	// Clamp a value into a legal range
	function automatic logic [GAIN_W-1:0] clamp_gain(
		input logic [15:0] v, input logic [GAIN_W-1:0] hi);
		if (v < 16'(UNITY_GAIN)) begin
			return UNITY_GAIN;
		end
		if (v > 16'(hi)) begin
			return hi;
		end
		return v[GAIN_W-1:0];
	endfunction

	// Computed auto white balance gains, green mean over channel mean
	logic [15:0] awb_gain [2];
	// Wide quotient saturates instead of wrapping on a dim channel
	logic [PIX_W+AWB_SAMPLES_LOG2+GAIN_FRAC-1:0] awb_quo [2];
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			awb_gain[i] = '0;
			awb_quo[i] = '0;
			if (sum_reg[i*2] != '0) begin
				awb_quo[i] = ({8'h00, sum_reg[1]} << GAIN_FRAC)
					/ {8'h00, sum_reg[i*2]};
				awb_gain[i] = (awb_quo[i] > 16'hffff) ? 16'hffff
					: awb_quo[i][15:0];
			end
		end
	end

	// Control, gain, offset and tone settings
	always_ff @(posedge clk) begin
		if (reset || (wr && addr == A_CTRL && wdata[CTRL_DEFAULTS])) begin
			fixed_gain_mode_reg <= 1'b1;
			luma_gain_reg <= UNITY_GAIN; // R1
			pixel_offset_level_reg <= '0; // R4
			tone_curve_exponent_reg <= TONE_ONE; // R6
			output_pixel_layout_reg <= LAY_RGB8;
		end else if (wr) begin
			case (addr)
				A_CTRL: begin
					fixed_gain_mode_reg <= wdata[CTRL_FIXED_GAIN];
				end
				A_LUMA_GAIN: begin
					luma_gain_reg <= clamp_gain(wdata, LUMA_MAX_GAIN); // R1
				end
				A_OFFSET: begin
					// Signed clamp to -5..+25 percent
					if ($signed(wdata[OFS_W-1:0]) < $signed(OFS_MIN)) begin
						pixel_offset_level_reg <= OFS_MIN; // R3
					end else if ($signed(wdata[OFS_W-1:0]) > $signed(OFS_MAX)) begin
						pixel_offset_level_reg <= OFS_MAX; // R3
					end else begin
						pixel_offset_level_reg <= wdata[OFS_W-1:0];
					end
				end
				A_TONE: begin
					if (wdata[7:0] < TONE_MIN) begin
						tone_curve_exponent_reg <= TONE_MIN; // R6
					end else if (wdata[7:0] > TONE_ONE) begin
						tone_curve_exponent_reg <= TONE_ONE; // R6
					end else begin
						tone_curve_exponent_reg <= wdata[7:0];
					end
				end
				A_LAYOUT: begin
					output_pixel_layout_reg <= wdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Selectors for white balance and matrix
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_channel_select_reg <= WB_NONE; // R8
			mix_row_select_reg <= CH_R; // R14
			mix_col_select_reg <= CH_R; // R14
		end else if (wr && COLOR) begin
			if (addr == A_WB_SEL && wdata[1:0] <= WB_BLUE) begin
				wb_channel_select_reg <= wb_sel_t'(wdata[1:0]);
			end
			if (addr == A_MIX_ROW && wdata[1:0] <= CH_B) begin
				mix_row_select_reg <= chan_t'(wdata[1:0]);
			end
			if (addr == A_MIX_COL && wdata[1:0] <= CH_B) begin
				mix_col_select_reg <= chan_t'(wdata[1:0]);
			end
		end
	end

	// White balance gains: software write or auto result
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_gain_reg[0] <= WB_RESET; // R9
			wb_gain_reg[1] <= WB_RESET;
		end else if (COLOR && awb_state_reg == AWB_DONE
				&& sum_reg[0] != '0 && sum_reg[2] != '0) begin // R11
			wb_gain_reg[0] <= clamp_gain(awb_gain[0], WB_MAX_GAIN); // R11
			wb_gain_reg[1] <= clamp_gain(awb_gain[1], WB_MAX_GAIN); // R11
		end else if (COLOR && wr && addr == A_WB_GAIN) begin
			// None selects no channel, so the write is dropped
			if (wb_channel_select_reg == WB_RED) begin
				wb_gain_reg[0] <= clamp_gain(wdata, WB_MAX_GAIN); // R8 R9
			end else if (wb_channel_select_reg == WB_BLUE) begin
				wb_gain_reg[1] <= clamp_gain(wdata, WB_MAX_GAIN); // R8 R9
			end
		end
	end

	// Matrix coefficients, one generate cell per element
	for (genvar i = 0; i < 3; i++) begin : g_row
		for (genvar j = 0; j < 3; j++) begin : g_col
			always_ff @(posedge clk) begin
				if (reset || i == j) begin
					// Diagonal is a constant and never written
					color_mix_coeff_reg[i][j] <= (i == j) ? COEF_ONE : '0; // R16 R17
				end else if (COLOR && wr && addr == A_MIX_COEF
						&& mix_row_select_reg == chan_t'(i)
						&& mix_col_select_reg == chan_t'(j)) begin // R15
					if ($signed(wdata[COEF_W-1:0]) > $signed(COEF_MAX)) begin
						color_mix_coeff_reg[i][j] <= COEF_MAX; // R17
					end else if ($signed(wdata[COEF_W-1:0]) < $signed(COEF_MIN)) begin
						color_mix_coeff_reg[i][j] <= COEF_MIN; // R17
					end else begin
						color_mix_coeff_reg[i][j] <= wdata[COEF_W-1:0];
					end
				end
			end
		end
	end

	// Auto white balance: wait frame, sum a window, then divide
	always_ff @(posedge clk) begin
		if (reset) begin
			awb_state_reg <= AWB_IDLE;
			auto_wb_request_reg <= 1'b0; // R10
			awb_ok_reg <= 1'b0;
			awb_cnt_reg <= '0;
			for (int k = 0; k < 3; k++) begin
				sum_reg[k] <= '0;
			end
		end else begin
			case (awb_state_reg)
				AWB_IDLE: begin
					// Off does nothing; layouts outside the list refuse
					if (COLOR && wr && addr == A_AUTO_WB && wdata[0]
							&& wb_layout_ok) begin // R10 R12
						auto_wb_request_reg <= 1'b1;
						awb_state_reg <= AWB_WAIT;
					end
				end
				AWB_WAIT: begin
					if (in_valid && in_sof) begin
						awb_state_reg <= AWB_SUM;
						awb_cnt_reg <= '0;
						for (int k = 0; k < 3; k++) begin
							sum_reg[k] <= '0;
						end
					end
				end
				AWB_SUM: begin
					if (in_valid) begin
						sum_reg[0] <= sum_reg[0] + (PIX_W+AWB_SAMPLES_LOG2)'(in_r);
						sum_reg[1] <= sum_reg[1] + (PIX_W+AWB_SAMPLES_LOG2)'(in_g);
						sum_reg[2] <= sum_reg[2] + (PIX_W+AWB_SAMPLES_LOG2)'(in_b);
						awb_cnt_reg <= awb_cnt_reg + 1'b1;
						if (awb_cnt_reg[AWB_SAMPLES_LOG2-1:0] == '1) begin
							awb_state_reg <= AWB_DONE;
						end
					end
				end
				AWB_DONE: begin
					// Dark scene counts as a failed run
					awb_ok_reg <= sum_reg[0] != '0 && sum_reg[2] != '0;
					auto_wb_request_reg <= 1'b0; // R10
					awb_state_reg <= AWB_IDLE;
				end
				default: begin
					awb_state_reg <= AWB_IDLE;
				end
			endcase
		end
	end

	// Each stage switches settings when the frame start reaches it,
	// so the sof pixel still uses the old settings and the rest of its frame the new
	always_ff @(posedge clk) begin
		if (reset) begin
			act_luma <= UNITY_GAIN;
			act_ofs <= '0;
			act_tone <= TONE_ONE;
			act_wb[0] <= WB_RESET;
			act_wb[1] <= WB_RESET;
			act_wb_en <= 1'b0;
			act_mix_en <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				for (int j = 0; j < 3; j++) begin
					act_mix[i][j] <= (i == j) ? COEF_ONE : '0;
				end
			end
		end else begin
			if (in_valid && in_sof) begin // R20
				act_luma <= fixed_gain_mode_reg ? luma_gain_reg : UNITY_GAIN; // R2
				act_wb <= wb_gain_reg;
				act_wb_en <= COLOR && wb_layout_ok; // R7 R12
			end
			if (s1_valid && s1_sof) begin // R20
				act_ofs <= pixel_offset_level_reg;
			end
			if (s2_valid && s2_sof) begin // R20
				act_mix <= color_mix_coeff_reg;
				act_mix_en <= COLOR && mix_layout_ok; // R7 R18
			end
			if (s3_valid && s3_sof) begin // R20
				act_tone <= tone_curve_exponent_reg;
			end
		end
	end

	// Stage 1: white balance and luma gain, saturate
	// Settings latch on the sof pixel and are used from the next one
	logic [PIX_W-1:0] s1_pix [3];
	logic [31:0] prod [3];
	// Balanced pixel, saturated before the luma gain sees it
	always_comb begin
		prod[0] = (32'(in_r) * (act_wb_en ? 32'(act_wb[0]) : 32'(UNITY_GAIN)))
			>> GAIN_FRAC;
		prod[1] = 32'(in_g);
		prod[2] = (32'(in_b) * (act_wb_en ? 32'(act_wb[1]) : 32'(UNITY_GAIN)))
			>> GAIN_FRAC;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_valid <= 1'b0;
			s1_sof <= 1'b0;
			for (int k = 0; k < 3; k++) begin
				s1_pix[k] <= '0;
			end
		end else begin
			s1_valid <= in_valid;
			s1_sof <= in_sof;
			for (int k = 0; k < 3; k++) begin
				// Gains both carry 8 fraction bits
				logic [47:0] g;
				g = 48'((prod[k] > 32'(PIX_MAX)) ? 32'(PIX_MAX) : prod[k])
					* 48'(act_luma); // R1 R19
				g = g >> GAIN_FRAC;
				s1_pix[k] <= (g > 48'(PIX_MAX)) ? PIX_MAX : g[PIX_W-1:0]; // R19
			end
		end
	end

	// Stage 2: offset, saturate both ways
	// A negative offset lowers white, so full scale may not be reached
	logic [PIX_W-1:0] s2_pix [3];
	always_ff @(posedge clk) begin
		if (reset) begin
			s2_valid <= 1'b0;
			s2_sof <= 1'b0;
			for (int k = 0; k < 3; k++) begin
				s2_pix[k] <= '0;
			end
		end else begin
			s2_valid <= s1_valid;
			s2_sof <= s1_sof;
			for (int k = 0; k < 3; k++) begin
				logic signed [12:0] v;
				v = $signed({2'b00, s1_pix[k]}) + 13'($signed(act_ofs)); // R3 R5
				if (v < 0) begin
					s2_pix[k] <= '0;
				end else if (v > $signed({3'b000, PIX_MAX})) begin
					s2_pix[k] <= PIX_MAX; // R19
				end else begin
					s2_pix[k] <= v[PIX_W-1:0];
				end
			end
		end
	end

	// Stage 3: colour matrix, row i = sum_j c_ij*x_j + (1 - sum c_ij)*x_i
	logic [PIX_W-1:0] s3_pix [3];
	always_ff @(posedge clk) begin
		if (reset) begin
			s3_valid <= 1'b0;
			s3_sof <= 1'b0;
			for (int k = 0; k < 3; k++) begin
				s3_pix[k] <= '0;
			end
		end else begin
			s3_valid <= s2_valid;
			s3_sof <= s2_sof;
			for (int i = 0; i < 3; i++) begin
				logic signed [24:0] acc;
				acc = $signed({1'b0, s2_pix[i], 7'h00});
				for (int j = 0; j < 3; j++) begin
					if (j != i) begin
						acc = acc + $signed({1'b0, s2_pix[j]})
							* $signed(act_mix[i][j])
							- $signed({1'b0, s2_pix[i]})
							* $signed(act_mix[i][j]); // R13
					end
				end
				acc = acc >>> COEF_FRAC;
				if (!act_mix_en) begin
					s3_pix[i] <= s2_pix[i]; // R18
				end else if (acc < 0) begin
					s3_pix[i] <= '0;
				end else if (acc > $signed({15'h0000, PIX_MAX})) begin
					s3_pix[i] <= PIX_MAX; // R19
				end else begin
					s3_pix[i] <= acc[PIX_W-1:0];
				end
			end
		end
	end

	// Stage 4: tone curve per channel
	for (genvar k = 0; k < 3; k++) begin : g_tone
		logic [PIX_W-1:0] t;
		tone_curve u_tone (
			.clk(clk),
			.reset(reset),
			.pix_in(s3_pix[k]),
			.exponent(act_tone), // R6
			.pix_out(t)
		);
		if (k == 0) begin : g_r
			assign out_r = t;
		end else if (k == 1) begin : g_g
			assign out_g = t;
		end else begin : g_b
			assign out_b = t;
		end
	end

	// Output qualifiers line up with the tone stage
	always_ff @(posedge clk) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_sof <= 1'b0;
		end else begin
			out_valid <= s3_valid;
			out_sof <= s3_sof;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset || !rd) begin
			rdata <= '0;
		end else begin
			case (addr)
				A_CTRL: rdata <= 16'(fixed_gain_mode_reg);
				A_LUMA_GAIN: rdata <= 16'(luma_gain_reg);
				A_OFFSET: rdata <= 16'($signed(pixel_offset_level_reg));
				A_TONE: rdata <= 16'(tone_curve_exponent_reg);
				A_WB_SEL: rdata <= 16'(wb_channel_select_reg);
				A_WB_GAIN: begin
					if (wb_channel_select_reg == WB_RED) begin
						rdata <= 16'(wb_gain_reg[0]);
					end else if (wb_channel_select_reg == WB_BLUE) begin
						rdata <= 16'(wb_gain_reg[1]);
					end else begin
						rdata <= '0;
					end
				end
				A_AUTO_WB: rdata <= 16'(auto_wb_request_reg);
				A_MIX_ROW: rdata <= 16'(mix_row_select_reg);
				A_MIX_COL: rdata <= 16'(mix_col_select_reg);
				A_MIX_COEF: rdata <= 16'($signed(
					color_mix_coeff_reg[mix_row_select_reg][mix_col_select_reg])); // R16
				A_LAYOUT: rdata <= 16'(output_pixel_layout_reg);
				A_STATUS: rdata <= {13'h0000, awb_ok_reg, COLOR,
					auto_wb_request_reg};
				default: rdata <= '0;
			endcase
		end
	end

endmodule

// [tb/pixel_color_adjust_pipeline_monitor.sv]
`timescale 1ns/1ps
// Port-level watch on the pixel stream and the register port
module pixel_color_adjust_pipeline_monitor
	import pix_adjust_pkg::*;
#(
	parameter bit COLOR = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	// Pixel input
	input wire logic in_valid,
	input wire logic in_sof,
	input wire logic [PIX_W-1:0] in_r,
	input wire logic [PIX_W-1:0] in_g,
	input wire logic [PIX_W-1:0] in_b,
	// Pixel output
	input wire logic out_valid,
	input wire logic out_sof,
	input wire logic [PIX_W-1:0] out_r,
	input wire logic [PIX_W-1:0] out_g,
	input wire logic [PIX_W-1:0] out_b
);
	logic [1:0] row_reg; // Mirrored row selector
	logic [1:0] col_reg; // Mirrored column selector
	logic [1:0] sel_reg; // Mirrored balance channel selector
	logic tone_set_reg; // Exponent written since reset
	logic ofs_set_reg; // Offset written since reset

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Selector mirror; restore leaves the selectors alone, so it needs no tracking
	always_ff @(posedge clk) begin
		if (reset) begin
			row_reg <= 2'h0;
			col_reg <= 2'h0;
			sel_reg <= 2'h0;
		end else if (wr && COLOR && wdata < 16'h0003) begin
			if (addr == A_MIX_ROW) row_reg <= wdata[1:0];
			if (addr == A_MIX_COL) col_reg <= wdata[1:0];
			if (addr == A_WB_SEL) sel_reg <= wdata[1:0];
		end
	end

	// Once written, the reset value no longer holds
	always_ff @(posedge clk) begin
		if (reset) begin
			tone_set_reg <= 1'b0;
			ofs_set_reg <= 1'b0;
		end else if (wr) begin
			if (addr == A_TONE) tone_set_reg <= 1'b1;
			if (addr == A_OFFSET) ofs_set_reg <= 1'b1;
		end
	end

	// Frame start in, frame start out after the fixed pipe depth
	sequence frame_start;
		in_valid && in_sof;
	endsequence
	sequence frame_out;
		##4 (out_valid && out_sof);
	endsequence

	pix_latency_a: assert property (
		in_valid |-> ##4 out_valid) else $error("pixel latency wrong");
	pix_gap_a: assert property (
		!in_valid |-> ##4 !out_valid) else $error("pixel out of nothing");
	frame_mark_a: assert property (
		frame_start |-> frame_out) else $error("frame start lost");
	sof_valid_a: assert property (
		out_sof |-> out_valid) else $error("frame start without pixel");
	diag_one_a: assert property (
		COLOR && rd && addr == A_MIX_COEF && row_reg == col_reg
		|=> rdata == 16'h0080) else $error("diagonal not one");
	tone_reset_a: assert property (
		rd && addr == A_TONE && !tone_set_reg |=> rdata == 16'h0064)
		else $error("exponent reset value wrong");
	tone_range_a: assert property (
		rd && addr == A_TONE |=> rdata inside {[16'h002d:16'h0064]})
		else $error("exponent out of range");
	ofs_reset_a: assert property (
		rd && addr == A_OFFSET && !ofs_set_reg |=> rdata == 16'h0000)
		else $error("offset reset value wrong");
	wb_range_a: assert property (
		rd && addr == A_WB_GAIN && sel_reg != 2'h0
		|=> rdata inside {[16'h0100:16'h0800]}) else $error("wb gain range");
	luma_range_a: assert property (
		rd && addr == A_LUMA_GAIN |=> rdata inside {[16'h0100:16'h07f8]})
		else $error("luma gain range");
	color_flag_a: assert property (
		rd && addr == A_STATUS |=> rdata[1] == COLOR)
		else $error("colour flag wrong");
endmodule

bind pixel_color_adjust_pipeline pixel_color_adjust_pipeline_monitor
	#(.COLOR(COLOR)) chk (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
	.in_valid, .in_sof, .in_r, .in_g, .in_b, .out_valid, .out_sof,
	.out_r, .out_g, .out_b);

// [tb/pixel_stream_model.sv]
`timescale 1ns/1ps
// Sensor readout side: one pixel per valid cycle, random idle gaps
module pixel_stream_model
	import pix_adjust_pkg::*;
(
	// Clock
	input wire logic clk,
	// Pixel stream toward the block
	output logic in_valid,
	output logic in_sof,
	output logic [PIX_W-1:0] in_r,
	output logic [PIX_W-1:0] in_g,
	output logic [PIX_W-1:0] in_b
);
	int seed = 88170; // Gap pattern seed

	initial begin
		in_valid = 1'b0;
		in_sof = 1'b0;
		in_r = '0;
		in_g = '0;
		in_b = '0;
	end

	// Release the stream; data is inverted so stale values are useless
	task automatic stop();
		@(posedge clk);
		in_valid <= 1'b0;
		in_sof <= 1'b0;
		in_r <= ~in_r;
		in_g <= ~in_g;
		in_b <= ~in_b;
	endtask

	// One pixel, sometimes followed by an idle cycle (slow source)
	task automatic send(logic [PIX_W-1:0] r, g, b, logic sof);
		@(posedge clk);
		in_valid <= 1'b1;
		in_sof <= sof;
		in_r <= r;
		in_g <= g;
		in_b <= b;
		if (($random(seed) & 3) == 0) stop();
	endtask
endmodule

// [tb/pixel_color_adjust_pipeline_bench.sv]
`timescale 1ns/1ps
// Integer model of the pipeline compared with the design per pixel
module pixel_color_adjust_pipeline_bench
	import pix_adjust_pkg::*;
;
	typedef struct {
		int lg, ofs, wbr, wbb, fix, lay;
		int c[3][3];
	} cfg_t;
	logic clk = 1'b0; // 200 MHz
	logic reset = 1'b1; // Held 8 cycles
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic in_valid, in_sof, out_valid, out_sof;
	logic [PIX_W-1:0] in_r, in_g, in_b, out_r, out_g, out_b;
	int num_errors = 0;
	int samples_checked = 0;
	int seed = 88170; // Pixel value seed
	int cyc = 0; // Watchdog count
	int q[$]; // Per pixel: r, g, b, sof, check flag
	cfg_t dflt = '{256, 0, 256, 256, 1, 1, '{default: 0}};
	cfg_t sh, act; // Written settings, settings in force
	logic [3:0] ra[11] = '{A_CTRL, A_LUMA_GAIN, A_OFFSET, A_TONE, A_WB_SEL,
		A_MIX_ROW, A_MIX_COL, A_MIX_COEF, A_LAYOUT, A_STATUS, 4'hf};
	logic [15:0] rv[11] = '{16'h0001, 16'h0100, 16'h0000, 16'h0064,
		16'h0000, 16'h0000, 16'h0000, 16'h0080, 16'h0001, 16'h0002, 16'h0};

	always #2.5 clk = ~clk;

	pixel_color_adjust_pipeline #(.COLOR(1'b1)) dut (.clk, .reset, .addr,
		.wdata, .wr, .rd, .rdata, .in_valid, .in_sof, .in_r, .in_g, .in_b,
		.out_valid, .out_sof, .out_r, .out_g, .out_b);
	pixel_stream_model src (.clk, .in_valid, .in_sof, .in_r, .in_g, .in_b);

	task automatic end_of_test();
		if (q.size() != 0) fail("pixels missing");
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic fail(string m);
		num_errors++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task automatic chk_reg(logic [15:0] got, logic [15:0] exp);
		samples_checked++;
		if (got !== exp) fail($sformatf("reg %h exp %h", got, exp));
	endtask
	task automatic chk_pix(logic [PIX_W-1:0] got, int exp);
		samples_checked++;
		if (got !== exp[PIX_W-1:0]) fail($sformatf("pix %0d exp %0d", got, exp));
	endtask
	task automatic wr_reg(logic [3:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(logic [3:0] a, logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk_reg(rdata, exp);
	endtask
	// Restore leaves balance gains, selectors and matrix as they stand
	task automatic restore();
		wr_reg(A_CTRL, 16'h0003);
		sh.lg = 256;
		sh.ofs = 0;
		sh.fix = 1;
		sh.lay = 1;
	endtask
	function automatic int sat(int v);
		return v < 0 ? 0 : (v > 1023 ? 1023 : v);
	endfunction
	// Expected value per stage order; new settings after a frame start
	task automatic px(int r, g, b, bit sof, bit chk);
		int p[3];
		int o[3];
		p = '{r, g, b};
		if (act.lay inside {[1:6]}) begin
			p[0] = sat(p[0] * act.wbr / 256);
			p[2] = sat(p[2] * act.wbb / 256);
		end
		for (int i = 0; i < 3; i++) begin
			if (act.fix != 0) p[i] = sat(p[i] * act.lg / 256);
			p[i] = sat(p[i] + act.ofs);
		end
		for (int i = 0; i < 3; i++) begin
			o[i] = p[i] * 128;
			for (int j = 0; j < 3; j++) o[i] += act.c[i][j] * (p[j] - p[i]);
			o[i] = act.lay inside {[1:4]} ? sat(o[i] >>> 7) : p[i];
		end
		q.push_back(o[0]);
		q.push_back(o[1]);
		q.push_back(o[2]);
		q.push_back(sof);
		q.push_back(chk);
		if (sof) act = sh;
		src.send(r[PIX_W-1:0], g[PIX_W-1:0], b[PIX_W-1:0], sof);
	endtask
	// Multiples of four keep fractional gains exact
	task automatic frame(int n, bit sof1);
		for (int k = 0; k < n; k++)
			px($random(seed) & 1020, $random(seed) & 1020,
				$random(seed) & 1020, sof1 && k == 0, 1'b1);
		src.stop();
	endtask
	task automatic note(string s);
		$display("test %s done", s);
	endtask

	// Output checker and watchdog
	always @(posedge clk) begin
		cyc++;
		if (out_valid === 1'b1) begin
			if (q.size() < 5) fail("unexpected pixel");
			else begin
				chk_pix({9'h000, out_sof}, q[3]);
				if (q[4] != 0) begin
					chk_pix(out_r, q[0]);
					chk_pix(out_g, q[1]);
					chk_pix(out_b, q[2]);
				end
				repeat (5) void'(q.pop_front());
			end
		end
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		sh = dflt;
		act = dflt;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		foreach (ra[i]) rd_reg(ra[i], rv[i]);
		frame(40, 1);
		note("reset and identity");
		frame(20, 1);
		wr_reg(A_OFFSET, 16'h0028);
		sh.ofs = 40;
		frame(20, 0);
		frame(30, 1);
		rd_reg(A_OFFSET, 16'h0028);
		wr_reg(A_OFFSET, {5'h1f, OFS_MIN});
		sh.ofs = -51;
		frame(40, 1);
		restore();
		rd_reg(A_OFFSET, 16'h0000);
		note("offset");
		wr_reg(A_LUMA_GAIN, 16'h0200);
		sh.lg = 512;
		frame(30, 1);
		wr_reg(A_CTRL, 16'h0000);
		sh.fix = 0;
		frame(30, 1);
		rd_reg(A_LUMA_GAIN, 16'h0200);
		note("gain");
		wr_reg(A_MIX_COL, 16'h0001);
		wr_reg(A_MIX_COEF, 16'h0040);
		sh.c[0][1] = 64;
		wr_reg(A_MIX_ROW, 16'h0002);
		wr_reg(A_MIX_COL, 16'h0000);
		wr_reg(A_MIX_COEF, 16'h0040);
		sh.c[2][0] = 64;
		wr_reg(A_MIX_COL, 16'h0002);
		wr_reg(A_MIX_COEF, 16'h0010);
		rd_reg(A_MIX_COEF, 16'h0080);
		wr_reg(A_MIX_COL, 16'h0000);
		rd_reg(A_MIX_COEF, 16'h0040);
		frame(40, 1);
		wr_reg(A_LAYOUT, {12'h000, LAY_BAYER8});
		sh.lay = 5;
		frame(30, 1);
		note("matrix");
		wr_reg(A_TONE, 16'h0010);
		rd_reg(A_TONE, 16'h002d);
		restore();
		wr_reg(A_WB_GAIN, 16'h0300);
		wr_reg(A_WB_SEL, 16'h0001);
		wr_reg(A_WB_GAIN, 16'h0200);
		wr_reg(A_WB_SEL, 16'h0002);
		wr_reg(A_WB_GAIN, 16'h0900);
		rd_reg(A_WB_GAIN, 16'h0800);
		wr_reg(A_WB_GAIN, 16'h0080);
		rd_reg(A_WB_GAIN, 16'h0100);
		wr_reg(A_WB_GAIN, 16'h0180);
		wr_reg(A_WB_SEL, 16'h0003);
		rd_reg(A_WB_SEL, 16'h0002);
		sh.wbr = 512;
		sh.wbb = 384;
		frame(30, 1);
		wr_reg(A_LAYOUT, {12'h000, LAY_MONO8});
		sh.lay = 0;
		frame(30, 1);
		note("white balance");
		restore();
		wr_reg(A_AUTO_WB, 16'h0001);
		for (int k = 0; k < 1100; k++) px(256, 512, 128, k == 0, 1'b0);
		src.stop();
		repeat (40) @(posedge clk);
		wr_reg(A_WB_SEL, 16'h0001);
		rd_reg(A_WB_GAIN, 16'h0200);
		wr_reg(A_WB_SEL, 16'h0002);
		rd_reg(A_WB_GAIN, 16'h0400);
		rd_reg(A_STATUS, 16'h0006);
		sh.wbr = 512;
		sh.wbb = 1024;
		frame(30, 1);
		note("auto balance");
		repeat (10) @(posedge clk);
		end_of_test();
	end
endmodule
